// ---- dmrb_pkg.sv ----
/*
 * dmrb_pkg: constants and carrier types for the drive monitor register bank.
 * Assumes a single 250 MHz system clock; all users refer to names by
 * dmrb_pkg::name and never import the package.
 */
package dmrb_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register addresses (word addresses of the serial register space)
  localparam logic [15:0] ADDR_SERIAL_CTRL = 16'h0001; // writable control reg
  localparam logic [15:0] ADDR_CURRENT_MON = 16'h0026;
  localparam logic [15:0] ADDR_PI_FEEDBACK = 16'h0057;
  localparam logic [15:0] ADDR_PI_DEVIATION = 16'h0063;
  localparam logic [15:0] ADDR_PI_OUTPUT = 16'h0064;
  localparam logic [15:0] ADDR_PI_SETPOINT = 16'h0065;
  localparam logic [15:0] ADDR_IP_BASE = 16'h07b0;
  localparam logic [15:0] ADDR_SUBNET_BASE = 16'h07b4;
  localparam logic [15:0] ADDR_GATEWAY_BASE = 16'h07b8;
  localparam logic [15:0] ADDR_PI_SECOND_FB = 16'h07d2;
  localparam logic [15:0] ADDR_PI_ADJUSTED_FB = 16'h07d3;
  localparam logic [15:0] ADDR_OPT_FREQ_REF = 16'h07dc;
  localparam logic [15:0] ADDR_RUN_SOURCE = 16'h07dd;
  localparam logic [15:0] ADDR_SERIAL_CW_MIRROR = 16'h07de;
  localparam logic [15:0] ADDR_OPT_CW_MIRROR = 16'h07df;
  localparam logic [15:0] ADDR_LINK_SPEED = 16'h07f2;
  localparam logic [15:0] ADDR_DUPLEX = 16'h07f3;
  localparam logic [15:0] ADDR_FIRST_OPT_FAULT = 16'h07f8;
  localparam logic [15:0] ADDR_CUR_OPT_FAULT = 16'h07f9;
  localparam logic [15:0] ADDR_TIME_HHMM = 16'h3000;
  localparam logic [15:0] ADDR_DATE_YEAR = 16'h3001;
  localparam logic [15:0] ADDR_DATE_MMDD = 16'h3002;
  localparam logic [15:0] ADDR_DATE_WEEKDAY = 16'h3003;

  ////////////////////////////////////////////////////////////////////////////
  // field layout of the run-command source monitor (bcd digits xy-nn)
  localparam int RUN_SEL_LSB = 12;
  localparam int RUN_ORIGIN_LSB = 8;
  localparam int RUN_LIMIT_LSB = 0;
  localparam logic [3:0] LIMIT_SOFT_CHARGE = 4'h3;
  localparam logic [7:0] DIFF_FEEDBACK_FUNC = 8'h16; // function setting 16
  localparam logic [15:0] SPEED_10M = 16'h000a;
  localparam logic [15:0] SPEED_100M = 16'h0064;
  localparam logic [15:0] RESET_WORD = 16'h0000;

  // current scaling: full rated current reads as 8192
  localparam logic [31:0] CURRENT_FULL_SCALE = 32'h0000_2000;
  localparam logic [31:0] PERCENT_FULL_SCALE = 32'h0000_2710; // 100.00 %

  ////////////////////////////////////////////////////////////////////////////
  // timing
  localparam longint unsigned CLK_HZ = 250_000_000;
  localparam longint unsigned UV_DELAY_S = 10;
  localparam longint unsigned UV_DELAY_CYC = UV_DELAY_S * CLK_HZ;
  localparam longint unsigned FLASH_HALF_MS = 500;
  localparam longint unsigned FLASH_HALF_CYC = FLASH_HALF_MS * CLK_HZ / 1000;

  ////////////////////////////////////////////////////////////////////////////
  // encodings
  typedef enum logic [1:0] {
    RUN_SEL_OFF = 2'b00,
    RUN_SEL_AUTO = 2'b01,
    RUN_SEL_HAND = 2'b10
  } dmrb_run_sel_e;

  typedef enum logic [2:0] {
    ORIGIN_KEYPAD = 3'b000,
    ORIGIN_TERMINALS = 3'b001,
    ORIGIN_NETWORK = 3'b011,
    ORIGIN_OPTION = 3'b100
  } dmrb_origin_e;

  typedef enum logic [1:0] {
    CHG_IDLE = 2'b00,
    CHG_WAIT = 2'b01,
    CHG_EXPIRED = 2'b10
  } dmrb_chg_e;

  ////////////////////////////////////////////////////////////////////////////
  // carriers
  typedef struct packed {
    logic [15:0] feedback;
    logic [15:0] second_feedback;
    logic [15:0] deviation;
    logic [15:0] output_value;
    logic [15:0] setpoint;
  } dmrb_pi_s;

  typedef struct packed {
    logic [4:0] hours;
    logic [5:0] minutes;
    logic [15:0] year;
    logic [3:0] month;
    logic [4:0] day;
    logic [2:0] weekday; // 0 sunday .. 6 saturday
  } dmrb_calendar_s;

  typedef struct packed {
    logic [31:0] ip_addr;
    logic [31:0] subnet;
    logic [31:0] gateway;
    logic speed_100m;
    logic full_duplex;
    logic [15:0] first_fault;
    logic [15:0] current_fault;
  } dmrb_network_s;

  typedef struct packed {
    dmrb_run_sel_e run_sel;
    dmrb_origin_e origin;
    logic [7:0] limit_bcd;
    logic soft_charge_wait;
  } dmrb_run_s;

endpackage

// ---- dmrb_monitor_bank.sv ----
/*
 * dmrb_monitor_bank: read-only monitor register bank of a bypass controller.
 * Holds the register read/write port, the control word mirrors and the
 * soft-charge wait timer. Assumes all inputs come from logic on sys_clk_i,
 * so no input is synchronised.
 */
`timescale 1ns/1ps
`default_nettype none

module dmrb_monitor_bank #(
  parameter longint unsigned UV_DELAY_CYCLES = dmrb_pkg::UV_DELAY_CYC,
  parameter longint unsigned FLASH_HALF_CYCLES = dmrb_pkg::FLASH_HALF_CYC
) (
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  // register port
  input wire logic rd_en_i,
  input wire logic wr_en_i,
  input wire logic [15:0] addr_i,
  input wire logic [15:0] wr_data_i,
  output logic [15:0] rd_data_o,
  output logic rd_valid_o,
  output logic rd_err_o,
  output logic wr_refused_o,
  // monitored values
  input wire dmrb_pkg::dmrb_run_s run_i,
  input wire logic opt_cw_wr_i,
  input wire logic [15:0] opt_cw_i,
  input wire logic opt_freq_wr_i,
  input wire logic [15:0] opt_freq_i,
  input wire logic [15:0] current_pct_i,
  input wire dmrb_pkg::dmrb_pi_s pi_i,
  input wire logic [7:0] analog_input_function_setting_i,
  input wire dmrb_pkg::dmrb_calendar_s calendar_i,
  input wire dmrb_pkg::dmrb_network_s network_i,
  // outputs to the controller
  output logic [15:0] serial_control_word_o,
  output logic undervoltage_indication_o
);

  ////////////////////////////////////////////////////////////////////////////
  // elaboration checks
  if (UV_DELAY_CYCLES < 1 || UV_DELAY_CYCLES > 64'h0000_0000_ffff_ffff) begin
    $error("UV_DELAY_CYCLES must fit in 32 bits and be nonzero");
  end
  if (FLASH_HALF_CYCLES < 1 ||
      FLASH_HALF_CYCLES > 64'h0000_0000_ffff_ffff) begin
    $error("FLASH_HALF_CYCLES must fit in 32 bits and be nonzero");
  end

  localparam logic [31:0] UV_LAST = 32'(UV_DELAY_CYCLES - 1);
  localparam logic [31:0] FLASH_LAST = 32'(FLASH_HALF_CYCLES - 1);

  ////////////////////////////////////////////////////////////////////////////
  // state
  typedef struct packed {
    dmrb_pkg::dmrb_chg_e chg;
    logic [31:0] wait_cnt;
    logic [31:0] flash_cnt;
    logic flash;
    logic [15:0] serial_cw;
    logic [15:0] option_cw;
    logic [15:0] option_freq;
    logic [15:0] rd_data;
    logic rd_valid;
    logic rd_err;
    logic wr_refused;
  } dmrb_state_s;

  dmrb_state_s state_ff;
  dmrb_state_s nxt_state;

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // two binary fields joined as four decimal digits, e.g. hhmm or mmdd
  function automatic logic [15:0] pair_decimal(input logic [6:0] hi,
                                               input logic [6:0] lo);
    logic [15:0] prod;
    prod = 16'(hi) * 16'h0064;
    return prod + 16'(lo);
  endfunction

  // one octet of a 32-bit address, index 0 is the most significant
  function automatic logic [15:0] octet(input logic [31:0] word,
                                        input logic [1:0] idx);
    logic [7:0] sel;
    case (idx)
      2'h0: sel = word[31:24];
      2'h1: sel = word[23:16];
      2'h2: sel = word[15:8];
      default: sel = word[7:0];
    endcase
    return {8'h00, sel};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // derived monitor values
  logic differential;
  logic [3:0] limit_hi;
  logic [3:0] limit_lo;
  logic [15:0] run_word;
  logic [15:0] adjusted_fb;
  logic [15:0] second_fb;
  logic [31:0] current_scaled;
  logic [31:0] current_prod;

  // differential feedback only when an analog input has function 16
  // second feedback gating
  assign differential =
    (analog_input_function_setting_i == dmrb_pkg::DIFF_FEEDBACK_FUNC);
  assign second_fb = differential ? pi_i.second_feedback :
                     dmrb_pkg::RESET_WORD;
  assign adjusted_fb = differential ?
                       16'(pi_i.feedback - pi_i.second_feedback) :
                       pi_i.feedback;

  // soft-charge wait overrides the reported limit code
  // limit code 03
  assign limit_hi = run_i.soft_charge_wait ? 4'h0 : run_i.limit_bcd[7:4];
  assign limit_lo = run_i.soft_charge_wait ? dmrb_pkg::LIMIT_SOFT_CHARGE :
                    run_i.limit_bcd[3:0];

  // bcd digits x, y and nn of the run source monitor
  // selection digit
  assign run_word = (16'({2'b00, run_i.run_sel}) << dmrb_pkg::RUN_SEL_LSB) |
                    (16'({1'b0, run_i.origin}) << dmrb_pkg::RUN_ORIGIN_LSB) |
                    (16'({limit_hi, limit_lo}) << dmrb_pkg::RUN_LIMIT_LSB);

  // constant divide keeps the scale exact; costs a fixed divider in area
  // 8192 full scale
  assign current_prod = 32'(current_pct_i) * dmrb_pkg::CURRENT_FULL_SCALE;
  assign current_scaled = current_prod / dmrb_pkg::PERCENT_FULL_SCALE;

  ////////////////////////////////////////////////////////////////////////////
  // read decode
  logic [15:0] rd_word;
  logic rd_hit;

  always_comb begin
    rd_word = dmrb_pkg::RESET_WORD;
    rd_hit = 1'b1;
    case (addr_i)
      dmrb_pkg::ADDR_RUN_SOURCE: rd_word = run_word;
      dmrb_pkg::ADDR_SERIAL_CW_MIRROR: rd_word = state_ff.serial_cw;
      dmrb_pkg::ADDR_OPT_CW_MIRROR: rd_word = state_ff.option_cw;
      dmrb_pkg::ADDR_OPT_FREQ_REF: rd_word = state_ff.option_freq;
      dmrb_pkg::ADDR_CURRENT_MON: rd_word = current_scaled[15:0];
      dmrb_pkg::ADDR_PI_FEEDBACK: rd_word = pi_i.feedback;
      dmrb_pkg::ADDR_PI_DEVIATION: rd_word = pi_i.deviation;
      dmrb_pkg::ADDR_PI_OUTPUT: rd_word = pi_i.output_value;
      dmrb_pkg::ADDR_PI_SETPOINT: rd_word = pi_i.setpoint;
      dmrb_pkg::ADDR_PI_SECOND_FB: rd_word = second_fb;
      dmrb_pkg::ADDR_PI_ADJUSTED_FB: rd_word = adjusted_fb;
      dmrb_pkg::ADDR_TIME_HHMM: begin
        rd_word = pair_decimal({2'b00, calendar_i.hours}, {1'b0,
                               calendar_i.minutes});
      end
      dmrb_pkg::ADDR_DATE_YEAR: rd_word = calendar_i.year;
      dmrb_pkg::ADDR_DATE_MMDD: begin
        rd_word = pair_decimal({3'b000, calendar_i.month},
                               {2'b00, calendar_i.day});
      end
      dmrb_pkg::ADDR_DATE_WEEKDAY: rd_word = {13'h0000, calendar_i.weekday};
      dmrb_pkg::ADDR_LINK_SPEED: begin
        rd_word = network_i.speed_100m ? dmrb_pkg::SPEED_100M :
                  dmrb_pkg::SPEED_10M;
      end
      dmrb_pkg::ADDR_DUPLEX: rd_word = {15'h0000, network_i.full_duplex};
      dmrb_pkg::ADDR_FIRST_OPT_FAULT: rd_word = network_i.first_fault;
      dmrb_pkg::ADDR_CUR_OPT_FAULT: rd_word = network_i.current_fault;
      default: begin
        if (addr_i[15:2] == dmrb_pkg::ADDR_IP_BASE[15:2]) begin
          rd_word = octet(network_i.ip_addr, addr_i[1:0]);
        end else if (addr_i[15:2] == dmrb_pkg::ADDR_SUBNET_BASE[15:2]) begin
          rd_word = octet(network_i.subnet, addr_i[1:0]);
        end else if (addr_i[15:2] == dmrb_pkg::ADDR_GATEWAY_BASE[15:2]) begin
          rd_word = octet(network_i.gateway, addr_i[1:0]);
        end else begin
          rd_hit = 1'b0;
        end
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    nxt_state = state_ff;
    nxt_state.rd_valid = rd_en_i;
    nxt_state.rd_err = rd_en_i && !rd_hit;
    nxt_state.rd_data = (rd_en_i && rd_hit) ? rd_word : dmrb_pkg::RESET_WORD;

    // only the control register accepts data; monitor writes are refused
    // writes ignored
    nxt_state.wr_refused = wr_en_i && (addr_i != dmrb_pkg::ADDR_SERIAL_CTRL);
    if (wr_en_i && addr_i == dmrb_pkg::ADDR_SERIAL_CTRL) begin
      nxt_state.serial_cw = wr_data_i;
    end
    if (opt_cw_wr_i) begin
      nxt_state.option_cw = opt_cw_i;
    end
    if (opt_freq_wr_i) begin
      nxt_state.option_freq = opt_freq_i;
    end

    // soft-charge wait timer; flashing only once the wait has run 10 s
    // wait timer and flash
    case (state_ff.chg)
      dmrb_pkg::CHG_IDLE: begin
        nxt_state.wait_cnt = 32'h0000_0000;
        nxt_state.flash_cnt = 32'h0000_0000;
        nxt_state.flash = 1'b0;
        if (run_i.soft_charge_wait) begin
          nxt_state.chg = dmrb_pkg::CHG_WAIT;
        end
      end
      dmrb_pkg::CHG_WAIT: begin
        if (!run_i.soft_charge_wait) begin
          nxt_state.chg = dmrb_pkg::CHG_IDLE;
        end else if (state_ff.wait_cnt >= UV_LAST) begin
          nxt_state.chg = dmrb_pkg::CHG_EXPIRED;
          nxt_state.flash = 1'b1;
        end else begin
          nxt_state.wait_cnt = state_ff.wait_cnt + 32'h0000_0001;
        end
      end
      dmrb_pkg::CHG_EXPIRED: begin
        if (!run_i.soft_charge_wait) begin
          nxt_state.chg = dmrb_pkg::CHG_IDLE;
          nxt_state.flash = 1'b0;
        end else if (state_ff.flash_cnt >= FLASH_LAST) begin
          nxt_state.flash_cnt = 32'h0000_0000;
          nxt_state.flash = !state_ff.flash;
        end else begin
          nxt_state.flash_cnt = state_ff.flash_cnt + 32'h0000_0001;
        end
      end
      default: begin
        nxt_state.chg = dmrb_pkg::CHG_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign rd_data_o = state_ff.rd_data;
  assign rd_valid_o = state_ff.rd_valid;
  assign rd_err_o = state_ff.rd_err;
  assign wr_refused_o = state_ff.wr_refused;
  assign serial_control_word_o = state_ff.serial_cw;
  assign undervoltage_indication_o = state_ff.flash;

endmodule

`default_nettype wire

// ---- dmrb_chk_monitor.sv ----
/*
 * dmrb_mon_chk: port assertions for the monitor register bank.
 * Assumes every port is on sys_clk_i; reset_n_i is async, active low.
 */
`timescale 1ns/1ps
`default_nettype none
module dmrb_mon_chk (
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic rd_en_i,
  input wire logic wr_en_i,
  input wire logic [15:0] addr_i,
  input wire logic [15:0] wr_data_i,
  input wire logic [15:0] rd_data_o,
  input wire logic wr_refused_o,
  input wire dmrb_pkg::dmrb_run_s run_i,
  input wire dmrb_pkg::dmrb_pi_s pi_i,
  input wire logic [7:0] analog_input_function_setting_i,
  input wire dmrb_pkg::dmrb_calendar_s calendar_i,
  input wire dmrb_pkg::dmrb_network_s network_i,
  input wire logic [15:0] serial_control_word_o,
  input wire logic undervoltage_indication_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);
  ////////////////////////////////////////////////////////////////////////////
  // a read request to one address
  sequence s_rd(a);
    rd_en_i && addr_i == a;
  endsequence
  property p_run_word;
    s_rd(dmrb_pkg::ADDR_RUN_SOURCE) |=> rd_data_o[15:8] ==
      {2'h0, $past(run_i.run_sel), 1'b0, $past(run_i.origin)};
  endproperty
  a_run_word: assert property (p_run_word)
    else $error("run source digits wrong");
  // limit digits forced to 03 while the bypass contactor is awaited
  property p_limit;
    s_rd(dmrb_pkg::ADDR_RUN_SOURCE) |=> rd_data_o[7:0] ==
      ($past(run_i.soft_charge_wait) ? 8'h03 : $past(run_i.limit_bcd));
  endproperty
  a_limit: assert property (p_limit)
    else $error("run limit digits wrong");
  property p_cw;
    wr_en_i && addr_i == dmrb_pkg::ADDR_SERIAL_CTRL |=>
      serial_control_word_o == $past(wr_data_i);
  endproperty
  a_cw: assert property (p_cw)
    else $error("control word not mirrored");
  property p_refuse;
    wr_en_i && addr_i != dmrb_pkg::ADDR_SERIAL_CTRL |=>
      wr_refused_o && $stable(serial_control_word_o);
  endproperty
  a_refuse: assert property (p_refuse)
    else $error("monitor write not refused");
  property p_adj;
    s_rd(dmrb_pkg::ADDR_PI_ADJUSTED_FB) |=> rd_data_o == $past(pi_i.feedback
      - (analog_input_function_setting_i == dmrb_pkg::DIFF_FEEDBACK_FUNC ?
      pi_i.second_feedback : 16'h0000));
  endproperty
  a_adj: assert property (p_adj)
    else $error("adjusted feedback wrong");
  property p_wday;
    s_rd(dmrb_pkg::ADDR_DATE_WEEKDAY) |=>
      rd_data_o == {13'h0, $past(calendar_i.weekday)};
  endproperty
  a_wday: assert property (p_wday)
    else $error("weekday wrong");
  property p_ip;
    s_rd(dmrb_pkg::ADDR_IP_BASE) |=>
      rd_data_o == {8'h00, $past(network_i.ip_addr[31:24])};
  endproperty
  a_ip: assert property (p_ip)
    else $error("ip top octet wrong");
  property p_speed;
    s_rd(dmrb_pkg::ADDR_LINK_SPEED) |=> rd_data_o ==
      ($past(network_i.speed_100m) ? 16'h0064 : 16'h000a);
  endproperty
  a_speed: assert property (p_speed)
    else $error("link speed wrong");
  // no flashing once the wait is over, and none in its first cycles
  property p_uv;
    !run_i.soft_charge_wait |=> !undervoltage_indication_o;
  endproperty
  a_uv: assert property (p_uv)
    else $error("undervoltage shown without wait");
  property p_uv_early;
    $rose(run_i.soft_charge_wait) |=> !undervoltage_indication_o [*8];
  endproperty
  a_uv_early: assert property (p_uv_early)
    else $error("undervoltage shown too early");
endmodule
bind dmrb_monitor_bank dmrb_mon_chk u_chk (.sys_clk_i(sys_clk_i),
  .reset_n_i(reset_n_i), .rd_en_i(rd_en_i), .wr_en_i(wr_en_i),
  .addr_i(addr_i), .wr_data_i(wr_data_i), .rd_data_o(rd_data_o),
  .wr_refused_o(wr_refused_o), .run_i(run_i), .pi_i(pi_i),
  .analog_input_function_setting_i(analog_input_function_setting_i),
  .calendar_i(calendar_i), .network_i(network_i),
  .serial_control_word_o(serial_control_word_o),
  .undervoltage_indication_o(undervoltage_indication_o));
`default_nettype wire

// ---- dmrb_card_host.sv ----
/*
 * dmrb_card_host: behavioural option card that posts control data and a
 * frequency reference. Assumes the caller is synchronous to sys_clk_i.
 */
`timescale 1ns/1ps
`default_nettype none
module dmrb_card_host (
  input wire logic sys_clk_i,
  output logic opt_cw_wr_o,
  output logic [15:0] opt_cw_o,
  output logic opt_freq_wr_o,
  output logic [15:0] opt_freq_o
);
  initial begin
    opt_cw_wr_o = 1'b0;
    opt_cw_o = 16'h0000;
    opt_freq_wr_o = 1'b0;
    opt_freq_o = 16'h0000;
  end
  // data inverted after the strobe so a stale capture shows up
  task automatic send(input logic [15:0] cw, input logic [15:0] fr);
    @(posedge sys_clk_i);
    opt_cw_wr_o <= 1'b1;
    opt_cw_o <= cw;
    opt_freq_wr_o <= 1'b1;
    opt_freq_o <= fr;
    @(posedge sys_clk_i);
    opt_cw_wr_o <= 1'b0;
    opt_cw_o <= ~cw;
    opt_freq_wr_o <= 1'b0;
    opt_freq_o <= ~fr;
  endtask
endmodule
`default_nettype wire

// ---- drive_monitor_register_bank_tb.sv ----
/*
 * drive_monitor_register_bank_tb: self-checking bench of the monitor bank.
 * Assumes short timer parameters: 20 cycles wait, 4 cycles flash half.
 */
`timescale 1ns/1ps
`default_nettype none
module drive_monitor_register_bank_tb;
  logic clk = 1'b0, rst_n = 1'b0, rd_en = 1'b0, wr_en = 1'b0;
  logic [15:0] addr = 16'h0000, wdat = 16'h0000, rdat, cw, fq;
  logic rvld, rerr, wref, cww, fqw, uv;
  logic [15:0] cur = 16'h0000;
  logic [7:0] af = 8'h00;
  dmrb_pkg::dmrb_run_s run = '0;
  dmrb_pkg::dmrb_pi_s pi = '0;
  dmrb_pkg::dmrb_calendar_s cal = '0;
  dmrb_pkg::dmrb_network_s net = '0;
  int n_fail = 0, n_tests = 0, cyc = 0, i, k, e;
  logic [15:0] d, scw;
  logic er;
  always #2 clk = ~clk;
  dmrb_card_host u_card (.sys_clk_i(clk), .opt_cw_wr_o(cww), .opt_cw_o(cw),
    .opt_freq_wr_o(fqw), .opt_freq_o(fq));
  dmrb_monitor_bank #(.UV_DELAY_CYCLES(20), .FLASH_HALF_CYCLES(4)) dut (
    .sys_clk_i(clk), .reset_n_i(rst_n), .rd_en_i(rd_en), .wr_en_i(wr_en),
    .addr_i(addr), .wr_data_i(wdat), .rd_data_o(rdat), .rd_valid_o(rvld),
    .rd_err_o(rerr), .wr_refused_o(wref), .run_i(run), .opt_cw_wr_i(cww),
    .opt_cw_i(cw), .opt_freq_wr_i(fqw), .opt_freq_i(fq),
    .current_pct_i(cur), .pi_i(pi), .analog_input_function_setting_i(af),
    .calendar_i(cal), .network_i(net), .serial_control_word_o(scw),
    .undervoltage_indication_o(uv));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    $display("counts: %0d compared, %0d failed", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // one read; the answer stands for one cycle after the taking edge
  task automatic rd(input logic [15:0] a);
    @(posedge clk);
    rd_en <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    d = rdat;
    er = rerr;
    chk({15'h0, rvld}, 16'h0001);
  endtask
  task automatic wr(input logic [15:0] a, input logic [15:0] v);
    @(posedge clk);
    wr_en <= 1'b1;
    addr <= a;
    wdat <= v;
    @(posedge clk);
    wr_en <= 1'b0;
    #1;
    chk({15'h0, wref}, {15'h0, a != 16'h0001});
  endtask
  // hang guard: whole run is a few hundred cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      give_verdict();
    end
  end
  initial begin
    void'($urandom(68358));
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    for (i = 0; i < 24; i++) begin
      // origin codes 0, 1, 3 and 4; code 2 names no origin
      k = (i / 3) % 4;
      k = (k < 2) ? k : k + 1;
      run.run_sel <= dmrb_pkg::dmrb_run_sel_e'(i % 3);
      run.origin <= dmrb_pkg::dmrb_origin_e'(k);
      run.limit_bcd <= 8'($urandom % 10);
      run.soft_charge_wait <= i[0];
      rd(dmrb_pkg::ADDR_RUN_SOURCE);
      e = (i % 3) * 4096 + k * 256;
      chk(d, 16'(e + (i[0] ? 3 : run.limit_bcd)));
    end
    $display("test run word done");
    e = $urandom;
    wr(16'h0001, 16'(e));
    wr(dmrb_pkg::ADDR_SERIAL_CW_MIRROR, ~16'(e));
    rd(dmrb_pkg::ADDR_SERIAL_CW_MIRROR);
    chk(d, 16'(e));
    chk(scw, 16'(e));
    rd(16'h0100);
    chk({15'h0, er}, 16'h0001);
    u_card.send(16'h5a3c, 16'h1770);
    rd(dmrb_pkg::ADDR_OPT_CW_MIRROR);
    chk(d, 16'h5a3c);
    rd(dmrb_pkg::ADDR_OPT_FREQ_REF);
    chk(d, 16'h1770);
    $display("test control words done");
    for (i = 0; i < 6; i++) begin
      k = (i == 0) ? 10000 : $urandom % 10001;
      cur <= 16'(k);
      pi <= {$urandom, $urandom, 16'($urandom)};
      af <= i[0] ? 8'h16 : 8'h15;
      rd(16'h0026);
      chk(d, 16'(k * 8192 / 10000));
      rd(dmrb_pkg::ADDR_PI_DEVIATION);
      chk(d, pi.deviation);
      rd(dmrb_pkg::ADDR_PI_SECOND_FB);
      chk(d, i[0] ? pi.second_feedback : 16'h0000);
      rd(dmrb_pkg::ADDR_PI_ADJUSTED_FB);
      e = pi.feedback - (i[0] ? pi.second_feedback : 0);
      chk(d, 16'(e));
      rd(dmrb_pkg::ADDR_PI_FEEDBACK);
      chk(d, pi.feedback);
      rd(dmrb_pkg::ADDR_PI_OUTPUT);
      chk(d, pi.output_value);
      rd(dmrb_pkg::ADDR_PI_SETPOINT);
      chk(d, pi.setpoint);
    end
    $display("test pi done");
    for (i = 0; i < 7; i++) begin
      // kept positive so the modulo fields stay in range
      k = $urandom % 100000;
      cal <= {5'(k % 24), 6'(k % 60), 16'(2000 + k % 100), 4'(1 + k % 12),
        5'(1 + k % 28), 3'(i)};
      rd(dmrb_pkg::ADDR_TIME_HHMM);
      chk(d, 16'((k % 24) * 100 + k % 60));
      rd(dmrb_pkg::ADDR_DATE_YEAR);
      chk(d, 16'(2000 + k % 100));
      rd(dmrb_pkg::ADDR_DATE_MMDD);
      chk(d, 16'((1 + k % 12) * 100 + 1 + k % 28));
      rd(dmrb_pkg::ADDR_DATE_WEEKDAY);
      chk(d, 16'(i));
    end
    $display("test calendar done");
    for (i = 0; i < 2; i++) begin
      net <= {$urandom, $urandom, $urandom, i[0], ~i[0], 32'($urandom)};
      for (k = 0; k < 12; k++) begin
        rd(16'(16'h07b0 + k));
        e = 32'(net >> (34 + 32 + 32 * (2 - k / 4) - 8 * (k % 4) - 8));
        chk(d, 16'(e & 255));
      end
      rd(dmrb_pkg::ADDR_LINK_SPEED);
      chk(d, i[0] ? 16'h0064 : 16'h000a);
      rd(dmrb_pkg::ADDR_DUPLEX);
      chk(d, {15'h0, ~i[0]});
      rd(dmrb_pkg::ADDR_FIRST_OPT_FAULT);
      chk(d, net.first_fault);
      rd(dmrb_pkg::ADDR_CUR_OPT_FAULT);
      chk(d, net.current_fault);
    end
    $display("test network done");
    // start from idle: the run word test left the wait raised
    run.soft_charge_wait <= 1'b0;
    repeat (2) @(posedge clk);
    run.soft_charge_wait <= 1'b1;
    for (k = 0; k < 60 && uv !== 1'b1; k++) begin
      @(posedge clk);
      #1;
    end
    chk(16'(k >= 20 && k <= 23), 16'h0001);
    run.soft_charge_wait <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chk({15'h0, uv}, 16'h0000);
    $display("test soft charge done");
    give_verdict();
  end
endmodule
`default_nettype wire
